// [bench/cmrc_host_model.sv]
// Host model issuing single-cycle A24 accesses to the relay bank
`timescale 1ns/1ps

module cmrc_host_model (
   input  wire logic        clk_i,
   output logic      [23:0] a24_addr_o,
   output logic             acc_valid_o,
   output logic             acc_write_o,
   output logic             acc_wide_o,
   output logic      [31:0] acc_wdata_o
);
   // Idle bus at time zero
   initial begin
      a24_addr_o  = 24'h000000;
      acc_valid_o = 1'b0;
      acc_write_o = 1'b0;
      acc_wide_o  = 1'b0;
      acc_wdata_o = 32'h00000000;
   end

   // One request, held through the taking edge; back to back allowed
   task automatic access(input logic [23:0] addr, input logic wr,
                         input logic wide, input logic [31:0] data);
      @(negedge clk_i);
      a24_addr_o  = addr;
      acc_write_o = wr;
      acc_wide_o  = wide;
      acc_wdata_o = data;
      acc_valid_o = 1'b1;
      @(posedge clk_i);
   endtask : access

   // Release the request; stale address and data lines flip so neither lingers
   task automatic idle;
      @(negedge clk_i);
      acc_valid_o = 1'b0;
      a24_addr_o  = ~a24_addr_o;
      acc_wdata_o = ~acc_wdata_o;
   endtask : idle
endmodule : cmrc_host_model

// [bench/tb.sv]
// Self-checking bench for the relay control register bank
`timescale 1ns/1ps

module tb;
   import cmrc_pkg::*;
   typedef struct {
      logic        rd;
      logic        err;
      logic [31:0] rdata;
      logic [31:0] word;
   } cmrc_note_s;
   logic        clk_i, reset_i, dev_reset_i, acc_valid_i, acc_write_i;
   logic        acc_wide_i, acc_ack_o, acc_err_o;
   logic [23:0] a24_base_i, a24_addr_i;
   logic [31:0] acc_wdata_i, acc_rdata_o, all_channel_word_o, shadow, w;
   logic [15:0] first_transfer_relay_o, second_transfer_relay_o;
   logic [23:0] bad [4] = '{24'h008002, 24'h008004, 24'h007FFE, 24'h000000};
   cmrc_note_s  notes [$];
   cmrc_note_s  nt;
   int          n_mismatch = 0;
   int          n_checks   = 0;
   int          seed       = 32'h101dc907;

   cmrc_relay_bank DUT (.clk_i(clk_i), .reset_i(reset_i),
      .dev_reset_i(dev_reset_i), .a24_base_i(a24_base_i),
      .a24_addr_i(a24_addr_i), .acc_valid_i(acc_valid_i),
      .acc_write_i(acc_write_i), .acc_wide_i(acc_wide_i),
      .acc_wdata_i(acc_wdata_i), .acc_ack_o(acc_ack_o),
      .acc_err_o(acc_err_o), .acc_rdata_o(acc_rdata_o),
      .first_transfer_relay_o(first_transfer_relay_o),
      .second_transfer_relay_o(second_transfer_relay_o),
      .all_channel_word_o(all_channel_word_o));

   cmrc_host_model HOST (.clk_i(clk_i), .a24_addr_o(a24_addr_i),
      .acc_valid_o(acc_valid_i), .acc_write_o(acc_write_i),
      .acc_wide_o(acc_wide_i), .acc_wdata_o(acc_wdata_i));

   // Value comparison with mismatch report
   task automatic chk(input string nm, input logic [31:0] e, g);
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
      n_checks++;
   endtask : chk

   // Relay drives expected from a word: first in high half
   function automatic logic [31:0] relays(input logic [31:0] wd);
      logic [31:0] r;
      for (int i = 0; i < 16; i++) begin
         r[16 + i] = wd[2 * i + 1];
         r[i]      = wd[2 * i];
      end
      return r;
   endfunction : relays

   // Note the expected answer, then hand the request to the host
   task automatic acc(input logic [23:0] off, input logic wr, wide,
                      input logic [31:0] d);
      cmrc_note_s n;
      logic       m;
      m = (off == CMRC_REG_OFFSET) || (off == CMRC_HIGH_HALF_OFFS && !wide);
      n.rd    = !wr;
      n.err   = !m;
      n.rdata = !m ? CMRC_UNMAPPED_DATA : wide ? shadow :
                off[1] ? {16'h0000, shadow[31:16]} : {16'h0000, shadow[15:0]};
      if (wr && m && !dev_reset_i) begin
         if (wide) shadow = d;
         else if (off[1]) shadow[31:16] = d[15:0];
         else shadow[15:0] = d[15:0];
      end
      n.word = shadow;
      notes.push_back(n);
      HOST.access(a24_base_i + off, wr, wide, d);
   endtask : acc

   // Final verdict and end of run
   task automatic close_out;
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // Oldest note against each acknowledge
   always @(negedge clk_i) begin
      if (acc_ack_o === 1'b1) begin
         if (notes.size() == 0) chk("spare_ack", 32'h0, 32'h1);
         else begin
            nt = notes.pop_front();
            chk("err", {31'h0, nt.err}, {31'h0, acc_err_o});
            if (nt.rd) chk("rdata", nt.rdata, acc_rdata_o);
            chk("word", nt.word, all_channel_word_o);
            chk("relays", relays(nt.word),
                {first_transfer_relay_o, second_transfer_relay_o});
         end
      end
   end

   // Clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Hang guard
   initial begin
      #20000;
      chk("timeout", 32'h0, 32'h1);
      close_out();
   end

   // Main sequence
   initial begin
      reset_i     = 1'b1;
      dev_reset_i = 1'b0;
      a24_base_i  = 24'h200000;
      shadow      = CMRC_REG_RESET;
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
      acc(CMRC_REG_OFFSET, 1'b0, 1'b1, 32'h0);
      // Each path code on each channel by read, clear, OR, write back
      for (int c = 0; c < CMRC_CHANNELS; c++) begin
         for (int p = 0; p < 4; p++) begin
            w = (shadow & ~(32'h3 << (2 * c))) | (32'(p) << (2 * c));
            if (c < 8) begin
               acc(CMRC_REG_OFFSET, 1'b0, 1'b1, 32'h0);
               acc(CMRC_REG_OFFSET, 1'b1, 1'b1, w);
            end else begin
               acc(CMRC_HIGH_HALF_OFFS, 1'b0, 1'b0, 32'h0);
               acc(CMRC_HIGH_HALF_OFFS, 1'b1, 1'b0,
                   {16'($random(seed)), w[31:16]});
            end
         end
      end
      // Random words back to back under random base addresses
      for (int i = 0; i < 40; i++) begin
         if (i % 8 == 0) begin
            HOST.idle();
            a24_base_i = 24'($random(seed));
         end
         acc(CMRC_REG_OFFSET, i[0], 1'b1, $random(seed));
      end
      // Unmapped places refuse and leave the register alone
      foreach (bad[k]) begin
         acc(bad[k], 1'b1, ~k[0], $random(seed));
         acc(bad[k], 1'b0, ~k[0], 32'h0);
      end
      // Device reset holds everything released
      HOST.idle();
      @(negedge clk_i);
      dev_reset_i = 1'b1;
      shadow      = CMRC_REG_RESET;
      acc(CMRC_REG_OFFSET, 1'b1, 1'b1, 32'hFFFFFFFF);
      acc(CMRC_REG_OFFSET, 1'b0, 1'b1, 32'h0);
      HOST.idle();
      @(negedge clk_i);
      dev_reset_i = 1'b0;
      acc(CMRC_REG_OFFSET, 1'b1, 1'b1, 32'hC0C0C0C0);
      acc(CMRC_REG_OFFSET, 1'b1, 1'b0,
          {16'($random(seed)), 16'h0080});
      acc(CMRC_REG_OFFSET, 1'b0, 1'b0, 32'h0);
      // Module reset in mid-run
      HOST.idle();
      @(negedge clk_i);
      reset_i = 1'b1;
      shadow  = CMRC_REG_RESET;
      repeat (2) @(negedge clk_i);
      reset_i = 1'b0;
      chk("reset_word", CMRC_REG_RESET, all_channel_word_o);
      acc(CMRC_REG_OFFSET, 1'b0, 1'b1, 32'h0);
      HOST.idle();
      for (int t = 0; t < 20 && notes.size() != 0; t++) @(negedge clk_i);
      chk("pending", 32'h0, 32'(notes.size()));
      close_out();
   end
endmodule : tb

// [design/cmrc_pkg.sv]
// Constants shared by the coax matrix relay control register bank
package cmrc_pkg;

   // Address map inside the module's A24 window (byte offsets)
   localparam logic [23:0] CMRC_REG_OFFSET     = 24'h008000;
   localparam logic [23:0] CMRC_HIGH_HALF_OFFS = 24'h008002;

   // Relay control register reset value: all relays released
   localparam logic [31:0] CMRC_REG_RESET      = 32'h00000000;

   // Channel field layout
   localparam int          CMRC_CHANNELS       = 16;
   localparam int          CMRC_FIELD_W        = 2;
   localparam int          CMRC_HALF_W         = 16;
   localparam int          CMRC_HALF_LSB       = 16;

   // Path codes of one channel field
   localparam logic [1:0]  CMRC_PATH_ONE       = 2'h0;
   localparam logic [1:0]  CMRC_PATH_TWO       = 2'h1;
   localparam logic [1:0]  CMRC_PATH_THREE     = 2'h2;
   localparam logic [1:0]  CMRC_PATH_FOUR      = 2'h3;

   // Bit inside a field that steers each transfer relay
   localparam int          CMRC_SECOND_BIT     = 0;
   localparam int          CMRC_FIRST_BIT      = 1;

   // Read data returned for an unmapped offset
   localparam logic [31:0] CMRC_UNMAPPED_DATA  = 32'h00000000;

   // Cycles from an accepted request to its acknowledge
   localparam int          CMRC_ACK_LATENCY    = 1;

endpackage : cmrc_pkg

// [design/cmrc_relay_bank.sv]
// Relay control register bank of a sixteen-channel one-of-four coax switch
`timescale 1ns/1ps

module cmrc_relay_bank
   import cmrc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        dev_reset_i,
   input  wire logic [23:0] a24_base_i,
   input  wire logic [23:0] a24_addr_i,
   input  wire logic        acc_valid_i,
   input  wire logic        acc_write_i,
   input  wire logic        acc_wide_i,
   input  wire logic [31:0] acc_wdata_i,
   output logic             acc_ack_o,
   output logic             acc_err_o,
   output logic [31:0]      acc_rdata_o,
   output logic [15:0]      first_transfer_relay_o,
   output logic [15:0]      second_transfer_relay_o,
   output logic [31:0]      all_channel_word_o
);

   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        ack_q;
   logic        err_q;

   // Offset of the access inside the module's window
   logic [23:0] offset;
   logic        hit_word;
   logic        hit_low_half;
   logic        hit_high_half;
   logic        hit_any;
   logic        wr_word;
   logic        wr_low;
   logic        wr_high;
   logic        rd_hit;
   logic [15:0] low_channel_half;
   logic [15:0] high_channel_half;
   logic [31:0] read_mux;

   // Address decode of the single relay control register
   assign offset        = a24_addr_i - a24_base_i;
   assign hit_word      = acc_wide_i && (offset == CMRC_REG_OFFSET);
   assign hit_low_half  = !acc_wide_i && (offset == CMRC_REG_OFFSET);
   assign hit_high_half = !acc_wide_i && (offset == CMRC_HIGH_HALF_OFFS);
   assign hit_any       = hit_word || hit_low_half || hit_high_half;

   // Write and read qualifiers
   assign wr_word = acc_valid_i && acc_write_i && hit_word;
   assign wr_low  = acc_valid_i && acc_write_i && hit_low_half;
   assign wr_high = acc_valid_i && acc_write_i && hit_high_half;
   assign rd_hit  = acc_valid_i && !acc_write_i && hit_any;

   // Halves of the control word, channel nine at bit 0 of the upper half
   assign low_channel_half  = ctrl_q[CMRC_HALF_W-1:0];
   assign high_channel_half = ctrl_q[CMRC_HALF_LSB +: CMRC_HALF_W];

   // Next control value; device reset holds the power-up state
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_word) begin
         ctrl_d = acc_wdata_i;
      end
      if (wr_low) begin
         ctrl_d[CMRC_HALF_W-1:0] = acc_wdata_i[CMRC_HALF_W-1:0];
      end
      if (wr_high) begin
         ctrl_d[CMRC_HALF_LSB +: CMRC_HALF_W] =
            acc_wdata_i[CMRC_HALF_W-1:0];
      end
      if (dev_reset_i) begin
         ctrl_d = CMRC_REG_RESET;
      end
   end

   // Read data selection; 16-bit reads land in the low lanes
   assign read_mux = hit_word      ? ctrl_q :
                     hit_low_half  ? {16'h0000, low_channel_half} :
                     hit_high_half ? {16'h0000, high_channel_half} :
                                     CMRC_UNMAPPED_DATA;

   // Read data holds until the next read
   always_comb begin
      rdata_d = rdata_q;
      if (acc_valid_i && !acc_write_i) begin
         rdata_d = read_mux;
      end
   end

   // Register state and access acknowledge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl_q  <= CMRC_REG_RESET;
         rdata_q <= CMRC_UNMAPPED_DATA;
         ack_q   <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         rdata_q <= rdata_d;
         ack_q   <= acc_valid_i;
         err_q   <= acc_valid_i && !hit_any;
      end
   end

   assign acc_ack_o          = ack_q;
   assign acc_err_o          = err_q;
   assign acc_rdata_o        = rdata_q;
   assign all_channel_word_o = ctrl_q;

   // Relay drive per channel, straight from the control flops
   genvar ch;
   generate
      for (ch = 0; ch < CMRC_CHANNELS; ch++) begin : g_chan
         // Upper bit of the field: first relay; lower bit: second relay
         assign first_transfer_relay_o[ch] =
            ctrl_q[CMRC_FIELD_W*ch + CMRC_FIRST_BIT];
         assign second_transfer_relay_o[ch] =
            ctrl_q[CMRC_FIELD_W*ch + CMRC_SECOND_BIT];

         // Field code and relay pair always agree
         chk_field_relays: assert property (
            @(posedge clk_i) disable iff (reset_i)
            {first_transfer_relay_o[ch], second_transfer_relay_o[ch]}
               == ctrl_q[CMRC_FIELD_W*ch +: CMRC_FIELD_W])
            else $error("relay pair differs from channel field");
      end
   endgenerate

   // Assertions guarding the register bank

   // Reset leaves every relay released one cycle later
   chk_reset_clears: assert property (
      @(posedge clk_i)
      reset_i |=> (ctrl_q == CMRC_REG_RESET) && !acc_ack_o
                  && (first_transfer_relay_o == 16'h0000)
                  && (second_transfer_relay_o == 16'h0000))
      else $error("reset did not clear relay control");

   // Path one code means neither relay is energized
   chk_path_one_idle: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (ctrl_q[7:6] == CMRC_PATH_ONE)
         |-> !first_transfer_relay_o[3] && !second_transfer_relay_o[3])
      else $error("path one field energizes a relay");

   // Word write at 8000h reaches all relays at the next edge
   chk_word_write: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && acc_write_i && acc_wide_i && !dev_reset_i
         && (a24_addr_i - a24_base_i == CMRC_REG_OFFSET))
      |=> (all_channel_word_o == $past(acc_wdata_i)))
      else $error("32-bit write not applied to relays");

   // Word read returns the whole register one cycle later
   chk_word_read: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && !acc_write_i && acc_wide_i
         && (a24_addr_i - a24_base_i == CMRC_REG_OFFSET))
      |=> acc_ack_o && (acc_rdata_o == $past(ctrl_q)))
      else $error("32-bit read returned wrong word");

   // High half write lands channel nine at bits 17:16
   chk_high_half: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && acc_write_i && !acc_wide_i && !dev_reset_i
         && (a24_addr_i - a24_base_i == CMRC_HIGH_HALF_OFFS))
      |=> (all_channel_word_o[31:16] == $past(acc_wdata_i[15:0]))
          && (all_channel_word_o[15:0] == $past(ctrl_q[15:0])))
      else $error("upper half write misplaced");

   // Low half write leaves channels nine to sixteen alone
   chk_low_half: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && acc_write_i && !acc_wide_i && !dev_reset_i
         && (a24_addr_i - a24_base_i == CMRC_REG_OFFSET))
      |=> (all_channel_word_o[15:0] == $past(acc_wdata_i[15:0]))
          && (all_channel_word_o[31:16] == $past(ctrl_q[31:16])))
      else $error("lower half write misplaced");

   // Written value is read back unchanged by a word read in the very next cycle
   chk_readback: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && acc_write_i && acc_wide_i && !dev_reset_i
         && (a24_addr_i - a24_base_i == CMRC_REG_OFFSET))
      ##1 (acc_valid_i && !acc_write_i && acc_wide_i && !dev_reset_i
         && (a24_addr_i - a24_base_i == CMRC_REG_OFFSET))
      |=> (acc_rdata_o == $past(acc_wdata_i, 2)))
      else $error("read back differs from last write");

   // Device reset keeps relays released for as long as it is held
   chk_dev_reset: assert property (
      @(posedge clk_i) disable iff (reset_i)
      dev_reset_i[*2] |-> (ctrl_q == CMRC_REG_RESET)
                          && (first_transfer_relay_o == 16'h0000)
                          && (second_transfer_relay_o == 16'h0000))
      else $error("relays energized under device reset");

   // Relays only move after a write, a device reset or a module reset
   chk_no_glitch: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !$stable(ctrl_q)
      |-> $past(reset_i) || $past(dev_reset_i)
          || ($past(acc_valid_i) && $past(acc_write_i)))
      else $error("relay drive changed without a write");

   // Path four code energizes both relays of channel four
   chk_path_four: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (ctrl_q[7:6] == CMRC_PATH_FOUR)
         |-> first_transfer_relay_o[3] && second_transfer_relay_o[3])
      else $error("path four field does not energize both relays");

   // Path two code drives only the second relay of channel four
   chk_path_two: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (ctrl_q[7:6] == CMRC_PATH_TWO)
         |-> !first_transfer_relay_o[3] && second_transfer_relay_o[3])
      else $error("path two field drives wrong relay");

   // Path three code drives only the first relay of channel eleven
   chk_path_three: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (ctrl_q[21:20] == CMRC_PATH_THREE)
         |-> first_transfer_relay_o[10] && !second_transfer_relay_o[10])
      else $error("path three field drives wrong relay");

   // Unmapped access is acknowledged with an error and no change
   chk_unmapped: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && !dev_reset_i
         && (a24_addr_i - a24_base_i != CMRC_REG_OFFSET)
         && (a24_addr_i - a24_base_i != CMRC_HIGH_HALF_OFFS))
      |=> acc_ack_o && acc_err_o && $stable(ctrl_q))
      else $error("unmapped access not refused");

   // Every request is acknowledged exactly one cycle later
   chk_ack_timing: assert property (
      @(posedge clk_i) disable iff (reset_i)
      acc_valid_i |=> acc_ack_o)
      else $error("access acknowledge missing");

   // No acknowledge or error without a request the cycle before
   chk_ack_pulse: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !acc_valid_i |=> !acc_ack_o && !acc_err_o)
      else $error("acknowledge without a request");

   // Mapped access of either width is acknowledged without error
   chk_mapped_ok: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && ((offset == CMRC_REG_OFFSET)
         || (!acc_wide_i && (offset == CMRC_HIGH_HALF_OFFS))))
      |=> acc_ack_o && !acc_err_o)
      else $error("mapped access refused");

   // 16-bit read of the low half returns channels one to eight
   chk_low_read: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && !acc_write_i && !acc_wide_i
         && (offset == CMRC_REG_OFFSET))
      |=> acc_ack_o
          && (acc_rdata_o == {16'h0000, $past(ctrl_q[15:0])}))
      else $error("16-bit low half read wrong");

   // 16-bit read of the high half returns channel nine at bit 0
   chk_high_read: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && !acc_write_i && !acc_wide_i
         && (offset == CMRC_HIGH_HALF_OFFS))
      |=> acc_ack_o
          && (acc_rdata_o == {16'h0000, $past(ctrl_q[31:16])}))
      else $error("16-bit high half read wrong");

   // Read of an unmapped place returns the unmapped pattern
   chk_unmapped_read: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (acc_valid_i && !acc_write_i && (offset != CMRC_REG_OFFSET)
         && !(!acc_wide_i && (offset == CMRC_HIGH_HALF_OFFS)))
      |=> acc_err_o && (acc_rdata_o == CMRC_UNMAPPED_DATA))
      else $error("unmapped read returned data");

   // Read data stands until the next read is taken
   chk_rdata_hold: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !(acc_valid_i && !acc_write_i) |=> $stable(acc_rdata_o))
      else $error("read data changed without a read");

endmodule : cmrc_relay_bank
